// ===== logic/pfp_defs.vh
// Constants for the program flash range protection block
`ifndef PFP_DEFS_VH
`define PFP_DEFS_VH
// Register byte offsets
`define PFP_OFS_PROT      12'h000
`define PFP_OFS_LOAD      12'h004
`define PFP_OFS_REQ       12'h008
`define PFP_OFS_STATUS    12'h00c
// Protection register fields
`define PFP_BIT_OPEN      7
`define PFP_BIT_HDIS      5
`define PFP_HS_HI         4
`define PFP_HS_LO         3
`define PFP_BIT_LDIS      2
`define PFP_LS_HI         1
`define PFP_LS_LO         0
// Reset value of the protection byte before the load
`define PFP_PROT_RST      8'hff
// Address map, 18-bit global flash addresses
`define PFP_LOW_BASE      18'h38000
`define PFP_TOP           18'h3ffff
`define PFP_LOAD_ADDR     18'h3ff0c
`define PFP_ARRAY_BASE    18'h30000
// Lower range last address per size code
`define PFP_LOW_END_0     18'h383ff
`define PFP_LOW_END_1     18'h387ff
`define PFP_LOW_END_2     18'h38fff
`define PFP_LOW_END_3     18'h39fff
// Higher range first address per size code
`define PFP_HIGH_START_0  18'h3f800
`define PFP_HIGH_START_1  18'h3f000
`define PFP_HIGH_START_2  18'h3e000
`define PFP_HIGH_START_3  18'h3c000
// Request field positions
`define PFP_REQ_GO        31
`define PFP_REQ_ERASE     30
`define PFP_REQ_ADDR_HI   17
// Status field position, write one to clear
`define PFP_BIT_VIOL      0
// Counter value at which the load sequence ends
`define PFP_LOAD_CYCLES   4'h4
// Counter value at which the read word is captured
`define PFP_LOAD_SAMPLE   4'h2
`endif

// ===== logic/pfp_range_check.v
// Address range decoder for the protection setting
`default_nettype none
module pfp_range_check (
    input  wire [17:0] addr,        // Global address
    input  wire [7:0]  prot,        // Protection setting byte
    output reg         is_prot      // Address is protected
);
`include "pfp_defs.vh"
    reg [17:0] low_end;
    reg [17:0] high_start;
    reg        in_low;
    reg        in_high;
    reg        in_array;
    // Range limits and membership
    always @* begin
        case (prot[`PFP_LS_HI:`PFP_LS_LO])
            2'b00:   low_end = `PFP_LOW_END_0;
            2'b01:   low_end = `PFP_LOW_END_1;
            2'b10:   low_end = `PFP_LOW_END_2;
            default: low_end = `PFP_LOW_END_3;
        endcase
        case (prot[`PFP_HS_HI:`PFP_HS_LO])
            2'b00:   high_start = `PFP_HIGH_START_0;
            2'b01:   high_start = `PFP_HIGH_START_1;
            2'b10:   high_start = `PFP_HIGH_START_2;
            default: high_start = `PFP_HIGH_START_3;
        endcase
        in_array = (addr >= `PFP_ARRAY_BASE);
        in_low   = !prot[`PFP_BIT_LDIS] && (addr >= `PFP_LOW_BASE)
                   && (addr <= low_end);
        in_high  = !prot[`PFP_BIT_HDIS] && (addr >= high_start);
        if (prot[`PFP_BIT_OPEN]) begin
            is_prot = in_low || in_high;
        end else begin
            is_prot = in_array && !(in_low || in_high);
        end
    end
endmodule // pfp_range_check
`default_nettype wire

// ===== logic/pfp_top.v
// APB program flash range protection controller
//
// The implementer's own choices: the APB slave port and the address map.
`default_nettype none
module pfp_top (
    input  wire        clk,            // Bus clock, 100 MHz
    input  wire        arst_n,         // Async reset, active low
    input  wire        psel,           // APB select
    input  wire        penable,        // APB enable
    input  wire        pwrite,         // APB write
    input  wire [11:0] paddr,          // APB byte address
    input  wire [31:0] pwdata,         // APB write data
    output reg  [31:0] prdata,         // APB read data
    output reg         pready,         // APB ready
    output reg         pslverr,        // APB error
    output reg  [17:0] flash_rd_addr,  // Flash read address for load
    output reg         flash_rd_en,    // Flash read strobe
    input  wire [7:0]  flash_rd_data,  // Flash read data, one cycle later
    output reg         op_go,          // Allowed program/erase pulse
    output reg         op_erase,       // Operation is erase
    output reg  [17:0] op_addr,        // Operation address
    output reg         prot_violation, // Violation pulse
    output reg         load_done       // Setting loaded
);
`include "pfp_defs.vh"

    // Protection setting byte and its next value
    reg  [7:0]  prot;
    reg  [7:0]  next_prot;

    // Load sequence counter and next values of its outputs
    reg  [3:0]  load_cnt;
    reg  [3:0]  next_load_cnt;
    reg         next_load_done;
    reg         next_flash_rd_en;
    reg  [17:0] next_flash_rd_addr;

    // Sticky violation flag and its next value
    reg         viol_flag;
    reg         next_viol_flag;

    // Next values of the operation outputs
    reg         next_op_go;
    reg         next_op_erase;
    reg  [17:0] next_op_addr;
    reg         next_prot_violation;

    // Next values of the bus answer
    reg         next_pready;
    reg         next_pslverr;
    reg  [31:0] next_prdata;

    // Range decoder interface
    reg  [17:0] chk_addr;
    wire        chk_prot;

    // Access phase taken once, before ready answers
    wire        acc      = psel && penable && !pready;
    wire        wr       = acc && pwrite;
    wire        rd       = acc && !pwrite;

    // Register selects on the byte address
    wire        sel_prot = (paddr == `PFP_OFS_PROT);
    wire        sel_load = (paddr == `PFP_OFS_LOAD);
    wire        sel_req  = (paddr == `PFP_OFS_REQ);
    wire        sel_stat = (paddr == `PFP_OFS_STATUS);
    wire        mapped   = sel_prot || sel_load || sel_req || sel_stat;

    // Qualified actions; software cannot touch the setting before the load
    wire        prot_wr  = wr && sel_prot && load_done;
    wire        req_go   = wr && sel_req && load_done && pwdata[`PFP_REQ_GO];
    wire        stat_clr = wr && sel_stat && pwdata[`PFP_BIT_VIOL];
    wire        capture  = !load_done && (load_cnt == `PFP_LOAD_SAMPLE);

    // Request word carries the target address in its low bits
    always @* begin
        chk_addr = pwdata[`PFP_REQ_ADDR_HI:0];
    end

    // Decoder on the request address and the current setting
    pfp_range_check u_chk (
        .addr    (chk_addr),
        .prot    (prot),
        .is_prot (chk_prot)
    );

    // Load sequence: one read strobe, capture two edges later, then release
    always @* begin
        next_load_cnt      = load_cnt;
        next_load_done     = load_done;
        next_flash_rd_en   = 1'b0;
        next_flash_rd_addr = flash_rd_addr;
        if (!load_done) begin
            next_load_cnt      = load_cnt + 4'h1;
            next_flash_rd_en   = (load_cnt == 4'h0);
            next_flash_rd_addr = `PFP_LOAD_ADDR;
            if (load_cnt == `PFP_LOAD_CYCLES) begin
                next_load_done = 1'b1;
            end
        end
    end

    // Load sequence registers
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            load_cnt      <= 4'h0;
            load_done     <= 1'b0;
            flash_rd_en   <= 1'b0;
            flash_rd_addr <= 18'h0;
        end else begin
            load_cnt      <= next_load_cnt;
            load_done     <= next_load_done;
            flash_rd_en   <= next_flash_rd_en;
            flash_rd_addr <= next_flash_rd_addr;
        end
    end

    // Next setting: loaded word first, then software writes
    always @* begin
        next_prot = prot;
        if (capture) begin
            next_prot = flash_rd_data;
        end else if (prot_wr) begin
            next_prot[`PFP_BIT_OPEN]         = pwdata[`PFP_BIT_OPEN];
            next_prot[`PFP_BIT_HDIS]         = pwdata[`PFP_BIT_HDIS];
            next_prot[`PFP_HS_HI:`PFP_HS_LO] = pwdata[`PFP_HS_HI:`PFP_HS_LO];
            next_prot[`PFP_BIT_LDIS]         = pwdata[`PFP_BIT_LDIS];
            // Size locked unless the low range is disabled right now
            if (prot[`PFP_BIT_LDIS]) begin
                next_prot[`PFP_LS_HI:`PFP_LS_LO] = pwdata[`PFP_LS_HI:`PFP_LS_LO];
            end
        end
    end

    // Protection setting register
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prot <= `PFP_PROT_RST;
        end else begin
            prot <= next_prot;
        end
    end

    // Sticky flag: a new violation wins over a clear in the same cycle
    always @* begin
        next_viol_flag = viol_flag;
        if (req_go && chk_prot) begin
            next_viol_flag = 1'b1;
        end else if (stat_clr) begin
            next_viol_flag = 1'b0;
        end
    end

    // Request outcome: blocked and flagged, or passed on
    always @* begin
        next_op_go          = req_go && !chk_prot;
        next_prot_violation = req_go && chk_prot;
        next_op_erase       = op_erase;
        next_op_addr        = op_addr;
        if (req_go) begin
            next_op_erase = pwdata[`PFP_REQ_ERASE];
            next_op_addr  = pwdata[`PFP_REQ_ADDR_HI:0];
        end
    end

    // Single-cycle outcome pulses and the sticky flag
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_go          <= 1'b0;
            prot_violation <= 1'b0;
            viol_flag      <= 1'b0;
        end else begin
            op_go          <= next_op_go;
            prot_violation <= next_prot_violation;
            viol_flag      <= next_viol_flag;
        end
    end

    // Fields of the last request, allowed or blocked
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_erase <= 1'b0;
            op_addr  <= 18'h0;
        end else begin
            op_erase <= next_op_erase;
            op_addr  <= next_op_addr;
        end
    end

    // Answer: ready one cycle after the access edge, data of that register
    always @* begin
        next_pready  = acc;
        next_pslverr = acc && !mapped;
        next_prdata  = 32'h0;
        if (rd) begin
            case (paddr)
                `PFP_OFS_PROT:   next_prdata = {24'h0, prot};
                `PFP_OFS_LOAD:   next_prdata = {31'h0, load_done};
                `PFP_OFS_STATUS: next_prdata = {31'h0, viol_flag};
                default:         next_prdata = 32'h0;
            endcase
        end
    end

    // APB handshake outputs: one wait state, error on unmapped address
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // APB read data, zero outside a read answer
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0;
        end else begin
            prdata <= next_prdata;
        end
    end
endmodule // pfp_top
`default_nettype wire

// ===== testbench/pfp_asserts.sv
// Concurrent checks on the ports of the protection controller
`default_nettype none
module pfp_asserts (
    input wire logic        clk,            // Bus clock
    input wire logic        arst_n,         // Async reset, active low
    input wire logic        psel,           // APB select
    input wire logic        penable,        // APB enable
    input wire logic        pready,         // APB ready
    input wire logic        pslverr,        // APB error
    input wire logic [31:0] pwdata,         // APB write data
    input wire logic        flash_rd_en,    // Flash read strobe
    input wire logic [17:0] flash_rd_addr,  // Flash read address
    input wire logic        op_go,          // Allowed operation pulse
    input wire logic        op_erase,       // Operation is erase
    input wire logic [17:0] op_addr,        // Operation address
    input wire logic        prot_violation, // Violation pulse
    input wire logic        load_done       // Setting loaded
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Access taken, then answered
    sequence s_take; psel && penable && !pready; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    property p_answer; s_take |=> s_answer; endproperty
    property p_load_addr; flash_rd_en |-> flash_rd_addr == 18'h3ff0c; endproperty
    property p_load_end; flash_rd_en |-> ##[1:6] load_done; endproperty
    property p_load_hold; load_done |=> load_done; endproperty
    property p_excl; !(op_go && prot_violation); endproperty
    property p_go_ready; (op_go || prot_violation) |-> pready && psel; endproperty
    property p_go_addr; op_go |-> op_addr == pwdata[17:0] && op_erase == pwdata[30]; endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    a_answer: assert property (p_answer) else $error("no single ready pulse");
    a_load_addr: assert property (p_load_addr) else $error("bad load address");
    a_load_end: assert property (p_load_end) else $error("load not done");
    a_load_hold: assert property (p_load_hold) else $error("load done dropped");
    a_excl: assert property (p_excl) else $error("go with violation");
    a_go_ready: assert property (p_go_ready) else $error("pulse outside access");
    a_go_addr: assert property (p_go_addr) else $error("wrong operation fields");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule // pfp_asserts
bind pfp_top pfp_asserts u_asserts (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .pwdata(pwdata), .flash_rd_en(flash_rd_en),
    .flash_rd_addr(flash_rd_addr), .op_go(op_go), .op_erase(op_erase), .op_addr(op_addr),
    .prot_violation(prot_violation), .load_done(load_done));
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the protection controller
`include "pfp_defs.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  flash_rd_data = 8'h00, flash_word = 8'h84, p;
    logic [17:0] flash_rd_addr, op_addr;
    logic pready, pslverr, flash_rd_en, op_go, op_erase, prot_violation, load_done;
    logic go_s, vi_s, er_s;
    int failures = 0, checks = 0, cycles = 0, q[$];
    pfp_top uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_rd_addr(flash_rd_addr), .flash_rd_en(flash_rd_en), .flash_rd_data(flash_rd_data),
        .op_go(op_go), .op_erase(op_erase), .op_addr(op_addr),
        .prot_violation(prot_violation), .load_done(load_done));
    always #5 clk = ~clk;
    // Flash partner: the word only in the cycle after the strobe, its inverse otherwise
    always @(posedge clk) begin
        if (flash_rd_en && flash_rd_addr == `PFP_LOAD_ADDR)
            flash_rd_data <= flash_word;
        else
            flash_rd_data <= ~flash_word;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One APB transfer, answer taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata; er_s = pslverr; go_s = op_go; vi_s = prot_violation;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Expected protection of one address
    function automatic logic exp_prot(input logic [7:0] s, input int a);
        logic lo, hi;
        lo = !s[2] && a >= 32'h38000 && a < 32'h38000 + (32'h400 << s[1:0]);
        hi = !s[5] && a >= 32'h40000 - (32'h800 << s[4:3]) && a <= 32'h3ffff;
        return s[7] ? (lo || hi) : (a >= 32'h30000 && a <= 32'h3ffff && !(lo || hi));
    endfunction
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        while (load_done !== 1'b1) @(posedge clk);
        apb(1'b0, `PFP_OFS_PROT, 32'h0);
        chk("prot after load", 32'(rd[7:0] & 8'hbf), 32'h84);
        apb(1'b0, `PFP_OFS_LOAD, 32'h0);
        chk("load status", rd, 32'h1);
        chk("mapped no error", 32'(er_s), 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'(er_s), 32'h1);
        $display("load test done");
        // Every polarity and disable combination, sizes varied
        for (int i = 0; i < 8; i++) begin
            p = {i[2], 1'b0, i[1], i[1:0] ^ 2'b10, i[0], i[1:0]};
            apb(1'b1, `PFP_OFS_PROT, 32'(p | 8'h04));
            apb(1'b1, `PFP_OFS_PROT, 32'(p));
            apb(1'b0, `PFP_OFS_PROT, 32'h0);
            chk("prot", 32'(rd[7:0] & 8'hbf), 32'(p));
            q = '{32'h37fff, 32'h38000, 32'h37fff + (32'h400 << p[1:0]),
                32'h38000 + (32'h400 << p[1:0]), 32'h3ffff - (32'h800 << p[4:3]),
                32'h40000 - (32'h800 << p[4:3]), 32'h3ffff};
            foreach (q[j]) begin
                apb(1'b1, `PFP_OFS_REQ, {1'b1, j[0], 12'h0, q[j][17:0]});
                chk("violation", 32'(vi_s), 32'(exp_prot(p, q[j])));
                chk("go", 32'(go_s), 32'(!exp_prot(p, q[j])));
            end
            $display("setting %0d done", i);
        end
        // Size kept when low range already enabled
        apb(1'b1, `PFP_OFS_PROT, 32'h00);
        apb(1'b1, `PFP_OFS_PROT, 32'h03);
        apb(1'b0, `PFP_OFS_PROT, 32'h0);
        chk("size locked", 32'(rd[7:0] & 8'hbf), 32'h00);
        apb(1'b0, `PFP_OFS_STATUS, 32'h0);
        chk("sticky set", 32'(rd[0]), 32'h1);
        apb(1'b1, `PFP_OFS_STATUS, 32'h1);
        apb(1'b0, `PFP_OFS_STATUS, 32'h0);
        chk("sticky clear", 32'(rd[0]), 32'h0);
        $display("status test done");
        // Second load in mid-run: new word, a write during loading is ignored
        flash_word <= 8'h23;
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        apb(1'b1, `PFP_OFS_PROT, 32'h80);
        while (load_done !== 1'b1) @(posedge clk);
        apb(1'b0, `PFP_OFS_PROT, 32'h0);
        chk("prot after reload", 32'(rd[7:0] & 8'hbf), 32'h23);
        apb(1'b0, `PFP_OFS_STATUS, 32'h0);
        chk("sticky after reset", 32'(rd[0]), 32'h0);
        $display("reload test done");
        results();
    end
endmodule // tb
`default_nettype wire
